/* File: logic/plp_pkg.sv */
// Constants and register map of the pixel output and luminance packing stage.
package plp_pkg;

  // Widths
  localparam int unsigned COMP_W = 12;
  localparam int unsigned LUMA_W = 16;
  localparam int unsigned PIX_W = 36;
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned RATE_W = 18;
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned STAT_W = 6;

  // Register byte addresses
  localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_RATE = 12'h004;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h008;

  // Control field positions and reset value
  localparam int unsigned CTRL_PORT_EN_BIT = 0;
  localparam int unsigned CTRL_LUMA_BIT = 1;
  localparam int unsigned CTRL_ILACE_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // Status field positions
  localparam int unsigned STAT_CABLE_BIT = 0;
  localparam int unsigned STAT_POWER_BIT = 1;
  localparam int unsigned STAT_DRIVE_BIT = 2;
  localparam int unsigned STAT_HS_BIT = 3;
  localparam int unsigned STAT_RATE_OK_BIT = 4;
  localparam int unsigned STAT_LUMA_BIT = 5;

  // Pixel rate in kHz: reset, guaranteed window and high-speed threshold
  localparam logic [RATE_W-1:0] RATE_MIN_KHZ = 18'h009C4;
  localparam logic [RATE_W-1:0] RATE_MAX_KHZ = 18'h2AB98;
  localparam logic [RATE_W-1:0] RATE_HS_KHZ = 18'h35B60;
  localparam logic [RATE_W-1:0] RATE_RESET = 18'h009C4;

  // Pixel clocks by which blank leads the data
  localparam int unsigned BLANK_LEAD = 3;

endpackage : plp_pkg

/* File: logic/plp_sync2.sv */
// Two-flop level synchroniser with a selectable reset value.
`timescale 1ns/100ps
`default_nettype none
module plp_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic RESET_VAL = 1'b0
) (
  clk,
  rst_n,
  d,
  q
);
  input wire logic clk;
  input wire logic rst_n;
  input wire logic [WIDTH-1:0] d;
  output logic [WIDTH-1:0] q;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{RESET_VAL}};
      sync_reg <= {WIDTH{RESET_VAL}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule : plp_sync2
`default_nettype wire

/* File: logic/plp_top.sv */
// Pixel output stage: APB registers, pixel-clock output registers and luminance packing.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module plp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [plp_pkg::APB_AW-1:0] paddr,
  input wire logic [plp_pkg::APB_DW-1:0] pwdata,
  output logic [plp_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic hs_path_sel,
  input wire logic pix_clk,
  input wire logic [plp_pkg::COMP_W-1:0] pix_red_in,
  input wire logic [plp_pkg::COMP_W-1:0] pix_green_in,
  input wire logic [plp_pkg::COMP_W-1:0] pix_blue_in,
  input wire logic [plp_pkg::LUMA_W-1:0] pix_luma_in,
  input wire logic pix_active_in,
  input wire logic pix_csync_in,
  input wire logic pix_vsync_in,
  input wire logic pix_field_in,
  input wire logic cable_present,
  input wire logic receiver_power_sense,
  output logic [plp_pkg::COMP_W-1:0] red_component_out,
  output logic [plp_pkg::COMP_W-1:0] green_component_out,
  output logic [plp_pkg::COMP_W-1:0] blue_component_out,
  output logic composite_blank,
  output logic csync_out,
  output logic vsync_out,
  output logic field_out,
  output logic clk_half_i,
  output logic clk_half_q,
  output logic [1:0] reserved_select_pair,
  output logic driver_enable
);
  import plp_pkg::*;

  // Pack one pixel: luminance spread over all buses, or plain RGB
  function automatic logic [PIX_W-1:0] pack_pixel(
    input logic luma,
    input logic [COMP_W-1:0] r,
    input logic [COMP_W-1:0] g,
    input logic [COMP_W-1:0] b,
    input logic [LUMA_W-1:0] l
  );
    return luma ? {l[15:4], l[15:4], l[15:8], l[3:0]} : {r, g, b};
  endfunction : pack_pixel

  // APB side, clocked by pclk
  logic pready_reg;
  logic pslverr_reg;
  logic [APB_DW-1:0] prdata_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [RATE_W-1:0] rate_reg;
  logic hs_path_reg;
  logic rate_ok_reg;
  logic [1:0] pins_p;
  logic [1:0] pix_stat_p;
  logic apb_done;
  logic apb_access;
  logic addr_hit;
  logic [APB_DW-1:0] rd_mux;

  assign apb_access = psel & penable & ~pready_reg;
  assign apb_done = psel & penable & pready_reg;

  // Pins and pixel-side state into the pclk domain
  plp_sync2 #(.WIDTH(2), .RESET_VAL(1'b0)) u_pins_p (
    .clk(pclk),
    .rst_n(presetn),
    .d({receiver_power_sense, cable_present}),
    .q(pins_p)
  );

  // Address decode and read mux for the three mapped words
  always_comb begin
    addr_hit = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_reg;
      ADDR_RATE: rd_mux[RATE_W-1:0] = rate_reg;
      ADDR_STATUS: begin
        rd_mux[STAT_CABLE_BIT] = pins_p[0];
        rd_mux[STAT_POWER_BIT] = pins_p[1];
        rd_mux[STAT_DRIVE_BIT] = pix_stat_p[0];
        rd_mux[STAT_HS_BIT] = hs_path_reg;
        rd_mux[STAT_RATE_OK_BIT] = rate_ok_reg;
        rd_mux[STAT_LUMA_BIT] = pix_stat_p[1];
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // One wait state: answer on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= apb_access;
      if (apb_access) begin
        pslverr_reg <= ~addr_hit;
        prdata_reg <= pwrite ? '0 : rd_mux;
      end
    end
  end

  // Writable registers; status writes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      rate_reg <= RATE_RESET;
    end else if (apb_done && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_reg <= pwdata[CTRL_W-1:0];
      end
      if (paddr == ADDR_RATE) begin
        rate_reg <= pwdata[RATE_W-1:0];
      end
    end
  end

  // Clock path choice follows the programmed rate only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_path_reg <= 1'b0;
      rate_ok_reg <= 1'b1;
    end else begin
      hs_path_reg <= (rate_reg > RATE_HS_KHZ);
      rate_ok_reg <= (rate_reg >= RATE_MIN_KHZ) && (rate_reg <= RATE_MAX_KHZ);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign hs_path_sel = hs_path_reg;

  // Link side, clocked by pix_clk
  logic pix_rst_n;
  logic [CTRL_W-1:0] ctrl_x;
  logic [1:0] pins_x;
  logic drv_en_reg;
  logic luma_cur_reg;
  logic vsync_prev_reg;
  logic frame_start;
  logic [PIX_W-1:0] pack_c;
  logic [PIX_W-1:0] pipe_reg [0:BLANK_LEAD-1];
  logic [PIX_W-1:0] data_out_reg;
  logic blank_reg;
  logic csync_reg;
  logic vsync_reg;
  logic field_reg;
  logic clk_i_reg;
  logic clk_q_reg;
  logic [1:0] rsv_reg;

  // Reset for the pixel domain: asserts at once, releases on pix_clk
  plp_sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_pix_rst (
    .clk(pix_clk),
    .rst_n(presetn),
    .d(1'b1),
    .q(pix_rst_n)
  );

  // Static settings cross as levels; software changes them only when idle
  plp_sync2 #(.WIDTH(CTRL_W), .RESET_VAL(1'b0)) u_ctrl_x (
    .clk(pix_clk),
    .rst_n(pix_rst_n),
    .d(ctrl_reg),
    .q(ctrl_x)
  );

  plp_sync2 #(.WIDTH(2), .RESET_VAL(1'b0)) u_pins_x (
    .clk(pix_clk),
    .rst_n(pix_rst_n),
    .d({receiver_power_sense, cable_present}),
    .q(pins_x)
  );

  plp_sync2 #(.WIDTH(2), .RESET_VAL(1'b0)) u_stat_p (
    .clk(pclk),
    .rst_n(presetn),
    .d({luma_cur_reg, drv_en_reg}),
    .q(pix_stat_p)
  );

  // Drivers run only with cable, good receiver power and the port enabled
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      drv_en_reg <= 1'b0;
    end else begin
      drv_en_reg <= pins_x[0] & pins_x[1] & ctrl_x[CTRL_PORT_EN_BIT];
    end
  end

  // First field start marks the frame boundary
  assign frame_start = pix_vsync_in & ~vsync_prev_reg & ~pix_field_in;

  // Luminance mode only moves between frames or while the drivers are off
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      vsync_prev_reg <= 1'b0;
      luma_cur_reg <= 1'b0;
    end else begin
      vsync_prev_reg <= pix_vsync_in;
      if (frame_start || !drv_en_reg) begin
        luma_cur_reg <= ctrl_x[CTRL_LUMA_BIT];
      end
    end
  end

  assign pack_c = pack_pixel(luma_cur_reg, pix_red_in, pix_green_in, pix_blue_in, pix_luma_in);

  // Data sits three stages longer than blank, so blank leads by that much
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      for (int i = 0; i < BLANK_LEAD; i++) begin
        pipe_reg[i] <= '0;
      end
    end else begin
      pipe_reg[0] <= pack_c;
      for (int i = 1; i < BLANK_LEAD; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  // Output registers on the rising pixel edge, quiet while shut down
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      data_out_reg <= '0;
      blank_reg <= 1'b0;
      csync_reg <= 1'b0;
      vsync_reg <= 1'b0;
      field_reg <= 1'b0;
      rsv_reg <= 2'h0;
    end else begin
      data_out_reg <= drv_en_reg ? pipe_reg[BLANK_LEAD-1] : '0;
      blank_reg <= drv_en_reg & pix_active_in;
      csync_reg <= drv_en_reg & pix_csync_in;
      vsync_reg <= drv_en_reg & pix_vsync_in;
      field_reg <= drv_en_reg & ctrl_x[CTRL_ILACE_BIT] & pix_field_in;
      rsv_reg <= 2'h0;
    end
  end

  // In-phase half-rate clock; stopped low while shut down
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      clk_i_reg <= 1'b0;
    end else begin
      clk_i_reg <= drv_en_reg & ~clk_i_reg;
    end
  end

  // Quadrature copy lags by half a pixel period, a quarter of its own
  always_ff @(negedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      clk_q_reg <= 1'b0;
    end else begin
      clk_q_reg <= clk_i_reg;
    end
  end

  assign red_component_out = data_out_reg[35:24];
  assign green_component_out = data_out_reg[23:12];
  assign blue_component_out = data_out_reg[11:0];
  assign composite_blank = blank_reg;
  assign csync_out = csync_reg;
  assign vsync_out = vsync_reg;
  assign field_out = field_reg;
  assign clk_half_i = clk_i_reg;
  assign clk_half_q = clk_q_reg;
  assign reserved_select_pair = rsv_reg;
  assign driver_enable = drv_en_reg;

  // Checks on the link and bus behaviour
  sequence s_drv_on;
    drv_en_reg ##1 drv_en_reg;
  endsequence

  a_blank_lead_three: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    s_drv_on |=> (composite_blank == $past(pix_active_in, 1))
      && (data_out_reg == $past(pack_c, 4)))
    else $error("blank does not lead data by three clocks");

  a_luma_red_green: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    ($past(drv_en_reg) && $past(luma_cur_reg, 4) && $past(drv_en_reg, 4))
      |-> (red_component_out == $past(pix_luma_in[15:4], 4))
      && (green_component_out == $past(pix_luma_in[15:4], 4)))
    else $error("luminance high bits wrong on red or green");

  a_luma_blue_low: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    ($past(drv_en_reg) && $past(luma_cur_reg, 4))
      |-> (blue_component_out[3:0] == $past(pix_luma_in[3:0], 4)))
    else $error("luminance low bits wrong on blue");

  a_luma_blue_high: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    ($past(drv_en_reg) && $past(luma_cur_reg, 4))
      |-> (blue_component_out[11:4] == $past(pix_luma_in[15:8], 4)))
    else $error("luminance top byte wrong on blue");

  a_rgb_pass: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    ($past(drv_en_reg) && !$past(luma_cur_reg, 4))
      |-> (red_component_out == $past(pix_red_in, 4))
      && (green_component_out == $past(pix_green_in, 4))
      && (blue_component_out == $past(pix_blue_in, 4)))
    else $error("rgb component not passed through");

  a_cable_off: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    !pins_x[0] |=> !driver_enable ##1 (data_out_reg == '0) && !composite_blank)
    else $error("drivers still on without cable");
  a_power_off: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    !pins_x[1] |=> !driver_enable ##1 !clk_half_i && !csync_out && !vsync_out)
    else $error("interface not shut down on bad receiver power");
  a_field_low: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    $past(drv_en_reg) |-> (field_out == ($past(ctrl_x[CTRL_ILACE_BIT]) && $past(pix_field_in))))
    else $error("field flag does not follow the interlace setting");
  a_half_clk: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    drv_en_reg |=> (clk_half_i != $past(clk_half_i)))
    else $error("half-rate clock not toggling");
  a_reserved_low: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    reserved_select_pair == 2'h0)
    else $error("reserved select driven high");
  a_luma_frame: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    $changed(luma_cur_reg) |-> $past(frame_start || !drv_en_reg))
    else $error("luminance mode changed inside a frame");
  a_hs_select: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_done && pwrite && paddr == ADDR_RATE && pwdata[RATE_W-1:0] > RATE_HS_KHZ)
      |=> ##1 hs_path_sel)
    else $error("high-speed path not selected for a fast rate");

endmodule : plp_top
`default_nettype wire

/* File: test/plp_rx_model.sv */
// Receiving board model: sense pins and full-rate clock rebuild.
`timescale 1ns/100ps
`default_nettype none
module plp_rx_model (
  input wire logic plug_in,
  input wire logic supply_ok,
  input wire logic clk_half_i,
  input wire logic clk_half_q,
  output logic cable_present,
  output logic receiver_power_sense,
  output logic rx_pix_clk
);
  // Sense pins follow the bench's plug and supply controls
  assign cable_present = plug_in;
  assign receiver_power_sense = supply_ok;
  // Quadrature pair rebuilds the pixel clock; no PLL over this wide range
  assign rx_pix_clk = clk_half_i ^ clk_half_q;
endmodule : plp_rx_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the pixel output stage.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import plp_pkg::*;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, pix_clk = 0;
  logic [APB_AW-1:0] paddr = 0;
  logic [APB_DW-1:0] pwdata = 0, prdata;
  logic pready, pslverr, hs_path_sel, driver_enable, plug_in = 1, supply_ok = 1;
  logic [COMP_W-1:0] pix_red_in = 0, pix_green_in = 0, pix_blue_in = 0;
  logic [COMP_W-1:0] red_component_out, green_component_out, blue_component_out;
  logic [LUMA_W-1:0] pix_luma_in = 0;
  logic pix_active_in = 0, pix_csync_in = 0, pix_vsync_in = 0, pix_field_in = 0;
  logic cable_present, receiver_power_sense, composite_blank, csync_out, vsync_out;
  logic field_out, clk_half_i, clk_half_q, rx_pix_clk;
  logic [1:0] reserved_select_pair;
  logic [2:0] bh = 0, fh = 0, ch = 0;
  logic [64:0] ae;
  logic [37:0] pe;
  logic [64:0] aq [$];
  logic [37:0] pq [$];
  int n_errors = 0, tests_run = 0, seed, rx_n = 0, n0;
  logic [31:0] rt [6] = '{32'h9C3, 32'h9C4, 32'h2AB98, 32'h2AB99, 32'h35B60, 32'h35B61};
  logic [1:0] st [6] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1};
  logic [2:0] md [3] = '{3'h5, 3'h3, 3'h1};

  // Two unrelated clocks: bus at 5 ns, link at 32 ns
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #3;
    forever #16 pix_clk = ~pix_clk;
  end

  plp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hs_path_sel(hs_path_sel), .pix_clk(pix_clk),
    .pix_red_in(pix_red_in), .pix_green_in(pix_green_in), .pix_blue_in(pix_blue_in),
    .pix_luma_in(pix_luma_in), .pix_active_in(pix_active_in), .pix_csync_in(pix_csync_in),
    .pix_vsync_in(pix_vsync_in), .pix_field_in(pix_field_in), .cable_present(cable_present),
    .receiver_power_sense(receiver_power_sense), .red_component_out(red_component_out),
    .green_component_out(green_component_out), .blue_component_out(blue_component_out),
    .composite_blank(composite_blank), .csync_out(csync_out), .vsync_out(vsync_out),
    .field_out(field_out), .clk_half_i(clk_half_i), .clk_half_q(clk_half_q),
    .reserved_select_pair(reserved_select_pair), .driver_enable(driver_enable));

  plp_rx_model rx (.plug_in(plug_in), .supply_ok(supply_ok), .clk_half_i(clk_half_i),
    .clk_half_q(clk_half_q), .cable_present(cable_present),
    .receiver_power_sense(receiver_power_sense), .rx_pix_clk(rx_pix_clk));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // One APB transfer; the note goes on the queue before the request starts
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
    int t;
    aq.push_back({e, m, d});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) chk("pready", 0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Bounded wait for the drivers to reach a level
  task automatic wait_de(input logic v);
    int t;
    t = 0;
    while (driver_enable !== v && t < 20) begin
      @(posedge pix_clk);
      t++;
    end
    #1;
    chk("driver_enable", driver_enable, v);
  endtask : wait_de

  // Random active pixels; each packed expectation is queued
  task automatic stream(input int n, input logic lm, input logic il);
    logic [35:0] v;
    logic [15:0] l;
    logic f;
    repeat (n) begin
      @(posedge pix_clk);
      v[31:0] = $random(seed);
      v[35:32] = 4'($random(seed));
      l = 16'($random(seed));
      f = 1'($random(seed));
      {pix_red_in, pix_green_in, pix_blue_in} <= v;
      pix_luma_in <= l;
      pix_field_in <= f;
      pix_csync_in <= v[0];
      pix_active_in <= 1'b1;
      pq.push_back({v[0], f & il, lm ? {l[15:4], l[15:4], l[15:8], l[3:0]} : v});
    end
    @(posedge pix_clk);
    pix_active_in <= 1'b0;
    repeat (6) @(posedge pix_clk);
  endtask : stream

  // Bus results: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      ae = aq.pop_front();
      chk("pslverr", pslverr, ae[64]);
      chk("prdata", prdata & ae[63:32], ae[31:0] & ae[63:32]);
    end
  end

  // Data is due three edges after blank was seen; a wrong lead misaligns it
  always @(posedge pix_clk) begin
    if (bh[2] === 1'b1) begin
      pe = pq.pop_front();
      chk("pixel", {red_component_out, green_component_out, blue_component_out},
          pe[35:0]);
      chk("field_out", fh[2], pe[36]);
      chk("csync_out", ch[2], pe[37]);
    end
    bh <= {bh[1:0], composite_blank & driver_enable};
    fh <= {fh[1:0], field_out};
    ch <= {ch[1:0], csync_out};
  end

  always @(posedge rx_pix_clk) rx_n++;

  // Watchdog: the whole run needs well under this span
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial begin
    seed = 69;
    // A real falling edge at time zero resets both domains at once
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, ADDR_CTRL, 0, 32'h7, 0);
    xfer(0, ADDR_RATE, {14'h0, RATE_RESET}, 32'h3FFFF, 0);
    xfer(0, 12'hFFC, 0, 32'hFFFFFFFF, 1);
    xfer(1, 12'h010, 32'h5, 0, 1);
    for (int i = 0; i < 6; i++) begin
      xfer(1, ADDR_RATE, rt[i], 0, 0);
      xfer(0, ADDR_RATE, rt[i], 32'h3FFFF, 0);
      xfer(0, ADDR_STATUS, {27'h0, st[i], 3'h0}, 32'h18, 0);
      #1;
      chk("hs_path_sel", hs_path_sel, st[i][0]);
    end
    $display("test registers done");
    // Mode changes only with the port off, luma bit set before enable
    for (int k = 0; k < 3; k++) begin
      xfer(1, ADDR_CTRL, 0, 0, 0);
      wait_de(0);
      xfer(1, ADDR_CTRL, {29'h0, md[k] & 3'h6}, 0, 0);
      xfer(1, ADDR_CTRL, {29'h0, md[k]}, 0, 0);
      wait_de(1);
      chk("reserved", reserved_select_pair, 0);
      stream(40, md[k][1], md[k][2]);
      #1;
      n0 = rx_n;
      repeat (8) @(posedge pix_clk);
      #1;
      chk("rx_clk_edges", rx_n - n0, 8);
      $display("test mode %0d done", md[k]);
    end
    // Luma set with the port on: packing must wait for the next frame start
    xfer(1, ADDR_CTRL, 32'h3, 0, 0);
    repeat (4) @(posedge pix_clk);
    stream(10, 1'b0, 1'b0);
    pix_vsync_in <= 1'b1;
    pix_field_in <= 1'b0;
    @(posedge pix_clk);
    pix_vsync_in <= 1'b0;
    #1;
    chk("vsync_out", vsync_out, 1);
    stream(10, 1'b1, 1'b0);
    $display("test frame switch done");
    // Cable pulled, then supply out of range
    for (int j = 0; j < 2; j++) begin
      if (j == 0) plug_in <= 1'b0;
      else supply_ok <= 1'b0;
      wait_de(0);
      @(posedge pix_clk);
      #1;
      chk("outputs_off", {red_component_out, green_component_out, blue_component_out,
          clk_half_i, clk_half_q, composite_blank, csync_out, vsync_out,
          field_out}, 0);
      plug_in <= 1'b1;
      supply_ok <= 1'b1;
      wait_de(1);
      stream(10, 1'b1, 1'b0);
      $display("test shutdown %0d done", j);
    end
    chk("pixels_left", pq.size(), 0);
    chk("bus_notes_left", aq.size(), 0);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
